/* core/sram_host_pkg.sv */
// constants, timing counts and state encoding for the async static memory host controller
package sram_host_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int TMR_W  = 4;

    // clock period in picoseconds (10 MHz)
    localparam int CLK_PERIOD_PS = 100000;

    // pin timing figures in ns
    localparam int ADDR_ACCESS_TIME_NS          = 30;
    localparam int OE_ACCESS_TIME_NS            = 15;
    localparam int DESELECT_TO_FLOAT_NS         = 15;
    localparam int READ_CYCLE_TIME_NS           = 30;
    localparam int WRITE_CYCLE_TIME_NS          = 40;
    localparam int WRITE_PULSE_WIDTH_NS         = 25;
    localparam int WRITE_RECOVERY_WIDTH_NS      = 15;
    localparam int DATA_SETUP_TO_END_NS         = 35;
    localparam int DATA_HOLD_AFTER_END_NS       = 5;
    localparam int ADDR_SETUP_TO_START_NS       = 0;
    localparam int STROBE_TO_FLOAT_NS           = 18;
    localparam int OUTPUT_ACTIVE_AFTER_WRITE_NS = 1;

    // least time in whole cycles, never below one
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    // data must float before anything else drives the bus, so waits are least times
    localparam int ACCESS_CYC = max2(max2(min_cycles(ADDR_ACCESS_TIME_NS),
                                          min_cycles(OE_ACCESS_TIME_NS)),
                                     min_cycles(READ_CYCLE_TIME_NS));
    localparam int FLOAT_CYC  = min_cycles(DESELECT_TO_FLOAT_NS);
    localparam int SETUP_CYC  = max2(min_cycles(ADDR_SETUP_TO_START_NS),
                                     min_cycles(STROBE_TO_FLOAT_NS));
    localparam int PULSE_CYC  = max2(min_cycles(WRITE_PULSE_WIDTH_NS),
                                     min_cycles(DATA_SETUP_TO_END_NS));
    localparam int HOLD_CYC   = max2(max2(min_cycles(DATA_HOLD_AFTER_END_NS),
                                          min_cycles(WRITE_RECOVERY_WIDTH_NS)),
                                     min_cycles(OUTPUT_ACTIVE_AFTER_WRITE_NS));
    localparam int WCYC_CYC   = min_cycles(WRITE_CYCLE_TIME_NS);

    localparam logic [TMR_W-1:0] ACCESS_LOAD = TMR_W'(ACCESS_CYC - 1);
    localparam logic [TMR_W-1:0] FLOAT_LOAD  = TMR_W'(FLOAT_CYC - 1);
    localparam logic [TMR_W-1:0] SETUP_LOAD  = TMR_W'(SETUP_CYC - 1);
    localparam logic [TMR_W-1:0] PULSE_LOAD  = TMR_W'(PULSE_CYC - 1);
    // stretch recovery if the three phases fall short of the write cycle time
    localparam logic [TMR_W-1:0] HOLD_LOAD   =
        TMR_W'(max2(HOLD_CYC, WCYC_CYC - SETUP_CYC - PULSE_CYC) - 1);

    // gray codes along idle -> setup -> pulse -> hold and idle -> access -> float
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_WR_SETUP  = 3'b001,
        ST_WR_PULSE  = 3'b011,
        ST_WR_HOLD   = 3'b010,
        ST_RD_ACCESS = 3'b100,
        ST_RD_FLOAT  = 3'b101
    } host_state_t;

endpackage : sram_host_pkg

/* core/sram_phase_timer.sv */
// down counter that times each phase of a memory cycle
`timescale 1ns/1ps
`default_nettype none
module sram_phase_timer
    import sram_host_pkg::*;
#(
    parameter int W = TMR_W
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              done
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    always_comb
    begin
        if (load)
            count_next = load_value;
        else if (count_reg != '0)
            count_next = count_reg - W'(1);
        else
            count_next = count_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    assign done = (count_reg == '0);

endmodule : sram_phase_timer
`default_nettype wire

/* core/sram_read_capture.sv */
// holds the word sampled from the data pins and flags it for one cycle
`timescale 1ns/1ps
`default_nettype none
module sram_read_capture
    import sram_host_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              capture,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata
);

    logic              valid_reg;
    logic              valid_next;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] data_next;

    always_comb
    begin
        valid_next = capture;
        data_next  = capture ? dq_in : data_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_reg <= 1'b0;
            data_reg  <= 16'h0000;
        end
        else
        begin
            valid_reg <= valid_next;
            data_reg  <= data_next;
        end
    end

    assign rsp_valid = valid_reg;
    assign rsp_rdata = data_reg;

endmodule : sram_read_capture
`default_nettype wire

/* core/sram_host_ctrl.sv */
// host controller driving a 128k x 16 asynchronous static memory through its pins
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module sram_host_ctrl
    import sram_host_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    // user request side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   busy,
    // memory pins
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   chip_select_n,
    output logic                   write_n,
    output logic                   output_enable_n,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe
);

    //////////////////////////////////////////////////////////////////////////
    // state and pin registers

    host_state_t       state_reg;
    host_state_t       state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic              cs_n_reg;
    logic              cs_n_next;
    logic              we_n_reg;
    logic              we_n_next;
    logic              oe_n_reg;
    logic              oe_n_next;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic              doe_reg;
    logic              doe_next;

    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_value;
    logic              tmr_done;
    logic              capture;
    logic              accept;

    // the same take decode feeds both register groups
    function automatic logic read_take(input logic take, input logic wr);
        return take && !wr;
    endfunction : read_take

    function automatic logic write_take(input logic take, input logic wr);
        return take && wr;
    endfunction : write_take

    //////////////////////////////////////////////////////////////////////////
    // phase timer and read data register

    sram_phase_timer #(
        .W          (TMR_W)
    ) u_timer (
        .clk        (clk),
        .rst_n      (rst_n),
        .load       (tmr_load),
        .load_value (tmr_value),
        .done       (tmr_done)
    );

    sram_read_capture u_capture (
        .clk        (clk),
        .rst_n      (rst_n),
        .capture    (capture),
        .dq_in      (dq_in),
        .rsp_valid  (rsp_valid),
        .rsp_rdata  (rsp_rdata)
    );

    //////////////////////////////////////////////////////////////////////////
    // request acceptance

    // a follow-on read is taken at the end of the current access so select stays low
    always_comb
    begin
        case (state_reg)
            ST_IDLE:      req_ready = 1'b1;
            ST_RD_ACCESS: req_ready = tmr_done && !req_write;
            default:      req_ready = 1'b0;
        endcase
    end

    assign accept = req_valid && req_ready;
    assign busy   = (state_reg != ST_IDLE);

    //////////////////////////////////////////////////////////////////////////
    // next state and next pin levels

    always_comb
    begin
        state_next = state_reg;
        cs_n_next  = cs_n_reg;
        we_n_next  = we_n_reg;
        oe_n_next  = oe_n_reg;
        tmr_load   = 1'b0;
        tmr_value  = '0;
        capture    = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (write_take(accept, req_write))
                begin
                    // address, select and data go out together, strobe still high
                    cs_n_next  = 1'b0;
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_value  = SETUP_LOAD;
                    state_next = ST_WR_SETUP;
                end
                else if (read_take(accept, req_write))
                begin
                    // select falls with the address, never after it
                    cs_n_next  = 1'b0;
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = ACCESS_LOAD;
                    state_next = ST_RD_ACCESS;
                end
            end
            ST_WR_SETUP:
            begin
                if (tmr_done)
                begin
                    // strobe falls last, opening the write window
                    we_n_next  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = PULSE_LOAD;
                    state_next = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE:
            begin
                if (tmr_done)
                begin
                    // strobe rises first and ends the write; data and address stay
                    we_n_next  = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_value  = HOLD_LOAD;
                    state_next = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD:
            begin
                if (tmr_done)
                begin
                    // data released only after the hold, and select rises too
                    cs_n_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_RD_ACCESS:
            begin
                if (tmr_done)
                begin
                    capture = 1'b1;
                    if (accept)
                    begin
                        // new address with select held low restarts the access
                        tmr_load   = 1'b1;
                        tmr_value  = ACCESS_LOAD;
                    end
                    else
                    begin
                        cs_n_next  = 1'b1;
                        oe_n_next  = 1'b1;
                        tmr_load   = 1'b1;
                        tmr_value  = FLOAT_LOAD;
                        state_next = ST_RD_FLOAT;
                    end
                end
            end
            ST_RD_FLOAT:
            begin
                // bus turnaround: nothing is driven until the memory has floated
                if (tmr_done)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
                cs_n_next  = 1'b1;
                we_n_next  = 1'b1;
                oe_n_next  = 1'b1;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cs_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cs_n_reg  <= cs_n_next;
            we_n_reg  <= we_n_next;
            oe_n_reg  <= oe_n_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // address and write data group

    // address and data move only at phase ends, never inside a write window
    always_comb
    begin
        addr_next = addr_reg;
        dout_next = dout_reg;
        doe_next  = doe_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (write_take(accept, req_write))
                begin
                    addr_next = req_addr;
                    dout_next = req_wdata;
                    doe_next  = 1'b1;
                end
                else if (read_take(accept, req_write))
                begin
                    addr_next = req_addr;
                    doe_next  = 1'b0;
                end
            end
            ST_WR_SETUP, ST_WR_PULSE, ST_RD_FLOAT:
            begin
                doe_next = doe_reg;
            end
            ST_WR_HOLD:
            begin
                if (tmr_done)
                    doe_next = 1'b0;
            end
            ST_RD_ACCESS:
            begin
                if (tmr_done && read_take(accept, req_write))
                    addr_next = req_addr;
            end
            default:
            begin
                doe_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= 17'h0_0000;
            dout_reg <= 16'h0000;
            doe_reg  <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
        end
    end

    // all pins come straight from flip-flops so no glitch reaches the strobes
    assign mem_addr        = addr_reg;
    assign chip_select_n   = cs_n_reg;
    assign write_n         = we_n_reg;
    assign output_enable_n = oe_n_reg;
    assign dq_out          = dout_reg;
    assign dq_oe           = doe_reg;

endmodule : sram_host_ctrl
`default_nettype wire

/* sim/sram_mem_model.sv */
// behavioural static memory seen at the controller pins
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model
    import sram_host_pkg::*;
(
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              chip_select_n,
    input  wire logic              write_n,
    input  wire logic              output_enable_n,
    input  wire logic [DATA_W-1:0] dq_bus,
    output logic      [DATA_W-1:0] dq_drv
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] last;
    logic              wr_act;
    logic              rd;
    assign wr_act = !write_n && !chip_select_n;
    assign rd = !chip_select_n && write_n && !output_enable_n;
    // the word lands when the first control rises
    always @(negedge wr_act)
        mem[int'(mem_addr)] = dq_bus;
    // released pins show the inverse word so a stale sample cannot pass
    // 15 ns keeps inside the oe access and float limits, the tightest ones
    always @(mem_addr or rd)
    begin
        if (rd)
            last = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : '0;
        dq_drv <= #15 rd ? last : ~last;
    end
endmodule : sram_mem_model
`default_nettype wire

/* sim/sram_host_ctrl_properties.sv */
// pin protocol checker for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_properties
    import sram_host_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic              busy,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              chip_select_n,
    input wire logic              write_n,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    a_write_select: assert property (!write_n |-> !chip_select_n && output_enable_n)
        else $error("strobe low without select");
    a_no_contend: assert property (dq_oe |-> output_enable_n)
        else $error("data driven while oe low");
    a_read_ctrl: assert property (!output_enable_n |-> !chip_select_n && write_n)
        else $error("oe low outside a read");
    a_read_walk: assert property (req_valid && req_ready && !req_write |=>
        !chip_select_n && !output_enable_n && mem_addr == $past(req_addr) ##1 rsp_valid)
        else $error("read cycle out of order");
    a_read_capture: assert property (rsp_valid |-> rsp_rdata == $past(dq_in))
        else $error("read word not the sampled pins");
    a_write_walk: assert property (req_valid && req_ready && req_write |=>
        !chip_select_n && write_n && dq_oe && mem_addr == $past(req_addr)
        && dq_out == $past(req_wdata) ##1 !write_n ##1 write_n)
        else $error("write cycle out of order");
    a_write_stable: assert property (!write_n |->
        $stable(mem_addr) && $stable(dq_out) && dq_oe && $past(!chip_select_n))
        else $error("address or data moved in write");
    a_write_hold: assert property ($rose(write_n) |->
        !chip_select_n && dq_oe && $stable(dq_out) && $stable(mem_addr))
        else $error("data not held past write end");
    a_write_recover: assert property ($rose(write_n) |-> write_n [*3])
        else $error("write recovery too short");
    a_float_first: assert property ($rose(dq_oe) |-> $past(output_enable_n))
        else $error("data driven before memory floats");
    a_idle_pins: assert property (!busy |-> req_ready && chip_select_n && write_n
        && output_enable_n && !dq_oe)
        else $error("pins active while idle");
    a_b2b_select: assert property (req_valid && req_ready && !req_write && !chip_select_n
        |=> !chip_select_n)
        else $error("select dropped between reads");
endmodule : sram_host_ctrl_properties
bind sram_host_ctrl sram_host_ctrl_properties sram_host_ctrl_properties_i (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .mem_addr(mem_addr),
    .chip_select_n(chip_select_n), .write_n(write_n), .output_enable_n(output_enable_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

/* sim/sram_host_ctrl_tb_top.sv */
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_tb_top;
    import sram_host_pkg::*;
    logic              clk;
    logic              rst_n;
    logic              req_valid;
    logic              req_ready;
    logic              req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic              busy;
    logic [ADDR_W-1:0] mem_addr;
    logic              chip_select_n;
    logic              write_n;
    logic              output_enable_n;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic [DATA_W-1:0] dq_drv;
    logic [DATA_W-1:0] ref_mem [int];
    logic [DATA_W-1:0] exp_q [$];
    int                num_errors;
    int                total_checks;
    int                cycles;
    int                seed;
    ////////////////////////////////////////////////////////////////////////////
    sram_host_ctrl sram_host_ctrl_i (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .mem_addr(mem_addr),
        .chip_select_n(chip_select_n), .write_n(write_n), .output_enable_n(output_enable_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    sram_mem_model sram_mem_model_i (
        .mem_addr(mem_addr), .chip_select_n(chip_select_n), .write_n(write_n),
        .output_enable_n(output_enable_n), .dq_bus(dq_in), .dq_drv(dq_drv));
    // the controller wins the pins only while it enables them
    assign dq_in = dq_oe ? dq_out : dq_drv;
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word
    // holds the request until taken, so reads chain with no idle cycle
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        @(negedge clk);
        while (req_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        if (wr)
            ref_mem[int'(a)] = d;
        else
            exp_q.push_back(ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : '0);
        #10;
    endtask : issue
    task automatic gap(input int k);
        req_valid = 1'b0;
        repeat (k) @(posedge clk);
        #10;
    endtask : gap
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk)
        if (rsp_valid === 1'b1)
            check_word(rsp_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    // a hang costs a mismatch and closes the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        seed = 32'hb01740c0;
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        repeat (3) @(posedge clk);
        #10 rst_n = 1'b1;
        // end addresses, writes back to back
        issue(1'b1, 17'h0_0000, 16'hffff);
        issue(1'b1, 17'h1_ffff, 16'h0001);
        // chained reads, then a write straight after a read
        issue(1'b0, 17'h0_0000, 16'h0000);
        issue(1'b0, 17'h1_ffff, 16'h0000);
        issue(1'b1, 17'h1_ffff, 16'h5a5a);
        issue(1'b0, 17'h1_ffff, 16'h0000);
        gap(3);
        // random mix over a small address pool so reads hit written words
        repeat (300)
        begin
            issue(1'($random(seed)), 17'($random(seed)) & 17'h1_0007,
                  16'($random(seed)));
            if ($random(seed) % 3 == 0)
                gap(1);
        end
        gap(6);
        check_word(DATA_W'(exp_q.size()), 16'h0000);
        check_word(DATA_W'(busy), 16'h0000);
        summarize();
    end
endmodule : sram_host_ctrl_tb_top
`default_nettype wire
